// file: logic/window_gamma_lut_select.sv
/*
 * Gamma table bank selection for the main window and two overlays.
 * Holds the gamma control register on a classic Wishbone slave, decodes
 * the bank and overlay fields and drives registered per-window selects.
 *
 * Control word (16 bits, low half of the bus word):
 *   [15]    not stored, reads zero
 *   [14]    main window bypass
 *   [13]    second overlay bypass
 *   [12]    first overlay bypass
 *   [11:10] overlay select, only used in the split bank mode
 *   [9:8]   table write colour, passed to the table datapath
 *   [7:6]   not stored, read zero
 *   [5:4]   display bank mode
 *   [3]     extra bit expansion, passed on
 *   [2]     extra bit clip disable, passed on
 *   [1]     table address auto increment, passed on
 *   [0]     table enable, stored and passed on, gates nothing here
 *
 * Status word (read only, follows the registered selects):
 *   [2:0]   window corrected: main, first, second overlay
 *   [5:3]   window uses bank B, same order
 *   [8:6]   window neither assigned nor bypassed
 *   [9]     host may reach bank A
 *   [10]    host may reach bank B
 *
 * Assumes the pixel pipeline runs on MCLK and the bus master is classic.
 * Bus inputs come from logic on MCLK, so none of them is synchronised.
 * Writes land on the edge at which the master sees ack.
 * The table banks and their access ports live outside this block.
 */
`timescale 1ns/100ps
`default_nettype none

module window_gamma_lut_select
    import gamma_sel_pkg::*;
#(
    parameter int ADR_W = 16
)
(
    // clock and reset
    input  wire logic              MCLK,
    input  wire logic              RST,
    // classic wishbone slave
    input  wire logic              CYC_I,
    input  wire logic              STB_I,
    input  wire logic              WE_I,
    input  wire logic [ADR_W-1:2]  ADR_I,
    input  wire logic [3:0]        SEL_I,
    input  wire logic [31:0]       DAT_I,
    output logic      [31:0]       DAT_O,
    output logic                   ACK_O,
    // per-window gamma selects
    output logic                   MAIN_GAMMA_EN,
    output logic                   MAIN_GAMMA_BANK_B,
    output logic                   PIP1_GAMMA_EN,
    output logic                   PIP1_GAMMA_BANK_B,
    output logic                   PIP2_GAMMA_EN,
    output logic                   PIP2_GAMMA_BANK_B,
    // host table access grants
    output logic                   HOST_BANK_A_EN,
    output logic                   HOST_BANK_B_EN,
    // remaining control fields for the table datapath
    output logic      [1:0]        WRITE_COLOR,
    output logic                   EXPAND_EN,
    output logic                   CLIP_DISABLE,
    output logic                   AUTO_INC,
    output logic                   LUT_ENABLE
);

    import gamma_sel_pkg::*;

    // registered control word and its per-window decode
    logic [15:0]        gamma_control;
    logic [NUM_WIN-1:0] assigned;
    logic [NUM_WIN-1:0] use_b;
    logic [NUM_WIN-1:0] bypass;
    logic [NUM_WIN-1:0] correct;
    logic [NUM_WIN-1:0] bank_b;
    logic [NUM_WIN-1:0] conflict;
    logic [1:0]         bank_sel;
    logic [1:0]         pip_sel;
    logic               host_a;
    logic               host_b;
    // bus decode and read views
    logic               req;
    logic               hit_ctrl;
    logic               hit_stat;
    logic [15:0]        status;
    logic [15:0]        next_control;

    // the two fields that steer the bank assignment
    assign bank_sel = gamma_control[BANK_SEL_LSB +: 2];
    assign pip_sel  = gamma_control[PIP_SEL_LSB +: 2];

    ////////////////////////////////////////////////////////////////////
    // bus decode: word index compare, unmapped reads return zero
    // only index bits 13:2 are decoded, so the registers alias upward;
    // a wider map must decode the upper address bits outside
    assign req      = CYC_I & STB_I;
    assign hit_ctrl = (ADR_I[13:2] == GAMMA_CONTROL_IDX);
    assign hit_stat = (ADR_I[13:2] == GAMMA_STATUS_IDX);

    // ack one cycle after the request, dropped the cycle after
    // keeping ack off for a cycle after each pulse stops a request
    // that is still held from being taken a second time
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            ACK_O <= 1'b0;
        else
            ACK_O <= req & ~ACK_O;
    end

    // read data is captured before ack so it is stable while ack is high
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            DAT_O <= 32'h0000_0000;
        else if (req & ~ACK_O & ~WE_I)
        begin
            if (hit_ctrl)
                DAT_O <= {16'h0000, gamma_control};
            else if (hit_stat)
                DAT_O <= {16'h0000, status};
            else
                DAT_O <= 32'h0000_0000;
        end
    end

    // byte lanes 0 and 1 carry the register; unstored bits stay zero
    // lanes 2 and 3 carry nothing and are dropped
    always_comb
    begin
        next_control = gamma_control;
        if (SEL_I[0])
            next_control[7:0] = DAT_I[7:0];
        if (SEL_I[1])
            next_control[15:8] = DAT_I[15:8];
        next_control = next_control & CONTROL_MASK;
    end

    // the write lands on the edge that completes the handshake
    // a cycle the master abandons before ack leaves the register as it
    // was, so a half finished access never changes the selects
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            gamma_control <= GAMMA_CONTROL_RST;
        else if (req & ACK_O & WE_I & hit_ctrl)
            gamma_control <= next_control;
    end

    ////////////////////////////////////////////////////////////////////
    // bank assignment per window from the display bank mode
    always_comb
    begin
        assigned = '0;
        use_b    = '0;
        unique case (bank_sel)
            // bank A serves main and first overlay, host gets bank B
            BANK_A_VIEW:
            begin
                assigned[WIN_MAIN] = 1'b1;
                assigned[WIN_PIP1] = 1'b1;
            end
            // the same windows on bank B, host gets bank A
            BANK_B_VIEW:
            begin
                assigned[WIN_MAIN] = 1'b1;
                assigned[WIN_PIP1] = 1'b1;
                use_b[WIN_MAIN]    = 1'b1;
                use_b[WIN_PIP1]    = 1'b1;
            end
            // main on bank A, selected overlays on bank B, no host
            BANK_SPLIT:
            begin
                assigned[WIN_MAIN] = 1'b1;
                use_b[WIN_PIP1]    = 1'b1;
                use_b[WIN_PIP2]    = 1'b1;
                // the overlay field is read in this mode only
                unique case (pip_sel)
                    PIP_BOTH:
                    begin
                        assigned[WIN_PIP1] = 1'b1;
                        assigned[WIN_PIP2] = 1'b1;
                    end
                    PIP_ONLY1:
                        assigned[WIN_PIP1] = 1'b1;
                    PIP_ONLY2:
                        assigned[WIN_PIP2] = 1'b1;
                    PIP_RESERVED:
                        assigned[WIN_PIP1] = 1'b0;
                endcase
            end
            // host owns both banks, nothing is corrected
            BANK_HOST:
                assigned = '0;
        endcase
    end

    // bypass bits per window
    // bypass wins over any assignment; software keeps it set for a
    // window that the bank mode leaves without a table
    assign bypass[WIN_MAIN] = gamma_control[MAIN_BYPASS_BIT];
    assign bypass[WIN_PIP1] = gamma_control[PIP1_BYPASS_BIT];
    assign bypass[WIN_PIP2] = gamma_control[PIP2_BYPASS_BIT];

    ////////////////////////////////////////////////////////////////////
    // one output stage per window, joined through the carrier interface
    // every stage registers its selects, so all windows switch on the
    // same edge and never show half of a control write
    genvar w;
    generate
        for (w = 0; w < NUM_WIN; w++)
        begin : g_win
            window_sel_if sel_bus ();

            assign sel_bus.assigned = assigned[w];
            assign sel_bus.use_b    = use_b[w];
            assign sel_bus.bypass   = bypass[w];
            assign correct[w]       = sel_bus.correct;
            assign bank_b[w]        = sel_bus.bank_b;
            assign conflict[w]      = sel_bus.conflict;

            window_gamma_route u_route
            (
                .clk (MCLK),
                .rst (RST),
                .sel (sel_bus.route)
            );
        end
    endgenerate

    assign MAIN_GAMMA_EN     = correct[WIN_MAIN];
    assign MAIN_GAMMA_BANK_B = bank_b[WIN_MAIN];
    assign PIP1_GAMMA_EN     = correct[WIN_PIP1];
    assign PIP1_GAMMA_BANK_B = bank_b[WIN_PIP1];
    assign PIP2_GAMMA_EN     = correct[WIN_PIP2];
    assign PIP2_GAMMA_BANK_B = bank_b[WIN_PIP2];

    ////////////////////////////////////////////////////////////////////
    // host access: a bank is never granted while it serves the display
    // grants follow the same control edge as the window selects, so no
    // bank shows as granted and displayed in one cycle
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            host_a <= 1'b0;
            host_b <= 1'b0;
        end
        else
        begin
            host_a <= (bank_sel == BANK_B_VIEW) | (bank_sel == BANK_HOST);
            host_b <= (bank_sel == BANK_A_VIEW) | (bank_sel == BANK_HOST);
        end
    end

    assign HOST_BANK_A_EN = host_a;
    assign HOST_BANK_B_EN = host_b;

    // plain control fields for the datapath, registered for timing
    // they only pass through; their effect lives in the table datapath
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            WRITE_COLOR  <= 2'h0;
            EXPAND_EN    <= 1'b0;
            CLIP_DISABLE <= 1'b0;
            AUTO_INC     <= 1'b0;
            LUT_ENABLE   <= 1'b0;
        end
        else
        begin
            WRITE_COLOR  <= gamma_control[WR_COLOR_LSB +: 2];
            EXPAND_EN    <= gamma_control[EXPAND_BIT];
            CLIP_DISABLE <= gamma_control[CLIP_DIS_BIT];
            AUTO_INC     <= gamma_control[AUTO_INC_BIT];
            LUT_ENABLE   <= gamma_control[LUT_EN_BIT];
        end
    end

    // status view of what the pipeline is really doing
    // built from the registered selects, so it lags control by one
    // cycle just as the window outputs do
    always_comb
    begin
        status = 16'h0000;
        status[STAT_CORRECT_LSB +: NUM_WIN]  = correct;
        status[STAT_BANK_B_LSB +: NUM_WIN]   = bank_b;
        status[STAT_CONFLICT_LSB +: NUM_WIN] = conflict;
        status[STAT_HOST_A_BIT]              = host_a;
        status[STAT_HOST_B_BIT]              = host_b;
    end

endmodule : window_gamma_lut_select

`default_nettype wire

// file: logic/gamma_sel_pkg.sv
/*
 * Constants for the gamma table bank selection block: register index,
 * field positions, reset value and bank and overlay encodings.
 * Assumes a 32-bit classic Wishbone register bus, word addressed.
 */
`default_nettype none

package gamma_sel_pkg;

    // register indices; byte address is four times the index
    localparam logic [11:0] GAMMA_CONTROL_IDX = 12'h83e;
    localparam logic [11:0] GAMMA_STATUS_IDX  = 12'h8f0;
    localparam logic [15:0] GAMMA_CONTROL_RST = 16'h0000;

    // control field positions
    localparam int MAIN_BYPASS_BIT = 14;
    localparam int PIP2_BYPASS_BIT = 13;
    localparam int PIP1_BYPASS_BIT = 12;
    localparam int PIP_SEL_LSB     = 10;
    localparam int WR_COLOR_LSB    = 8;
    localparam int BANK_SEL_LSB    = 4;
    localparam int EXPAND_BIT      = 3;
    localparam int CLIP_DIS_BIT    = 2;
    localparam int AUTO_INC_BIT    = 1;
    localparam int LUT_EN_BIT      = 0;
    // bits 15, 7 and 6 are not stored and read as zero
    localparam logic [15:0] CONTROL_MASK = 16'h7f3f;

    // status field positions
    localparam int STAT_CORRECT_LSB  = 0;
    localparam int STAT_BANK_B_LSB   = 3;
    localparam int STAT_CONFLICT_LSB = 6;
    localparam int STAT_HOST_A_BIT   = 9;
    localparam int STAT_HOST_B_BIT   = 10;

    // window numbering inside the block
    localparam int WIN_MAIN = 0;
    localparam int WIN_PIP1 = 1;
    localparam int WIN_PIP2 = 2;
    localparam int NUM_WIN  = 3;

    // display bank select encodings
    localparam logic [1:0] BANK_A_VIEW  = 2'h0;
    localparam logic [1:0] BANK_B_VIEW  = 2'h1;
    localparam logic [1:0] BANK_SPLIT   = 2'h2;
    localparam logic [1:0] BANK_HOST    = 2'h3;

    // overlay select encodings
    localparam logic [1:0] PIP_BOTH     = 2'h0;
    localparam logic [1:0] PIP_ONLY1    = 2'h1;
    localparam logic [1:0] PIP_ONLY2    = 2'h2;
    localparam logic [1:0] PIP_RESERVED = 2'h3;

endpackage : gamma_sel_pkg

`default_nettype wire

// file: logic/window_sel_if.sv
/*
 * Carries one window's selection between the control decoder and the
 * per-window output stage. Assumes both ends share one clock.
 */
`timescale 1ns/100ps
`default_nettype none

interface window_sel_if;
    logic assigned;   // bank mode gives this window a table
    logic use_b;      // that table is bank B
    logic bypass;     // software bypass bit
    logic correct;    // registered: window is corrected
    logic bank_b;     // registered: correction uses bank B
    logic conflict;   // registered: unassigned but not bypassed

    modport ctrl  (output assigned, output use_b, output bypass,
                   input correct, input bank_b, input conflict);
    modport route (input assigned, input use_b, input bypass,
                   output correct, output bank_b, output conflict);
endinterface : window_sel_if

`default_nettype wire

// file: logic/window_gamma_route.sv
/*
 * Output stage for one display window: merges the bank assignment with
 * the window's bypass bit into registered select outputs.
 * Assumes inputs come from logic on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

module window_gamma_route
(
    // clock and reset
    input  wire logic     clk,
    input  wire logic     rst,
    // selection of this window
    window_sel_if.route   sel
);

    ////////////////////////////////////////////////////////////////////
    // a set bypass bit always wins over the bank assignment
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sel.correct <= 1'b0;
            sel.bank_b  <= 1'b0;
        end
        else
        begin
            sel.correct <= sel.assigned & ~sel.bypass;
            sel.bank_b  <= sel.assigned & ~sel.bypass & sel.use_b;
        end
    end

    // flag a setting software should never leave; correction stays off
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            sel.conflict <= 1'b0;
        else
            sel.conflict <= ~sel.assigned & ~sel.bypass;
    end

endmodule : window_gamma_route

`default_nettype wire

// file: tb/gamma_sel_monitor.sv
/* checker for the gamma bank select block: bus timing and selects.
   assumes it is bound to the top module and sees its ports only. */
`timescale 1ns/100ps
`default_nettype none
module gamma_sel_monitor
    import gamma_sel_pkg::*;
#(
    parameter int ADR_W = 16
)
(
    // clock, reset and bus
    input wire logic             MCLK,
    input wire logic             RST,
    input wire logic             CYC_I,
    input wire logic             STB_I,
    input wire logic             WE_I,
    input wire logic [ADR_W-1:2] ADR_I,
    input wire logic [3:0]       SEL_I,
    input wire logic [31:0]      DAT_I,
    input wire logic [31:0]      DAT_O,
    input wire logic             ACK_O,
    // window selects and grants
    input wire logic             MAIN_GAMMA_EN,
    input wire logic             MAIN_GAMMA_BANK_B,
    input wire logic             PIP1_GAMMA_EN,
    input wire logic             PIP1_GAMMA_BANK_B,
    input wire logic             PIP2_GAMMA_EN,
    input wire logic             PIP2_GAMMA_BANK_B,
    input wire logic             HOST_BANK_A_EN,
    input wire logic             HOST_BANK_B_EN
);
    logic [15:0] ctrl;
    logic [15:0] ctrl_d;
    logic        ok;
    logic        hit;
    logic [1:0]  md;
    logic [1:0]  ps;
    // control access at the ack edge; mode and overlay as the selects see
    assign hit = CYC_I && STB_I && ACK_O && ADR_I[13:2] == GAMMA_CONTROL_IDX;
    assign md = ctrl_d[BANK_SEL_LSB +: 2];
    assign ps = ctrl_d[PIP_SEL_LSB +: 2];
    // shadow of the control register, lanes 0 and 1 only
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            ctrl <= GAMMA_CONTROL_RST;
        else if (hit && WE_I)
            ctrl <= {SEL_I[1] ? DAT_I[15:8] : ctrl[15:8],
                     SEL_I[0] ? DAT_I[7:0] : ctrl[7:0]} & CONTROL_MASK;
    end
    // selects lag control by one cycle; ok skips the edge after reset
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            ctrl_d <= GAMMA_CONTROL_RST;
            ok     <= 1'b0;
        end
        else
        begin
            ctrl_d <= ctrl;
            ok     <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    sequence s_take;
        CYC_I && STB_I && !ACK_O;
    endsequence
    sequence s_pulse;
        ACK_O ##1 !ACK_O;
    endsequence
    a_ack_pulse: assert property (s_take |=> s_pulse)
        else $error("ack is not a one cycle answer");
    a_ack_cause: assert property (ACK_O |-> $past(CYC_I && STB_I))
        else $error("ack without a request");
    a_read_back: assert property (hit && !WE_I |-> DAT_O == {16'h0, ctrl})
        else $error("control read data wrong");
    a_main_bypass: assert property (ok && ctrl_d[14] |-> !MAIN_GAMMA_EN)
        else $error("main corrected while bypassed");
    a_pip2_bypass: assert property (ok && ctrl_d[13] |-> !PIP2_GAMMA_EN)
        else $error("overlay two corrected while bypassed");
    a_pip1_bypass: assert property (ok && ctrl_d[12] |-> !PIP1_GAMMA_EN)
        else $error("overlay one corrected while bypassed");
    a_main_bank: assert property (ok && !ctrl_d[14] |->
        MAIN_GAMMA_EN == (md != BANK_HOST)
        && MAIN_GAMMA_BANK_B == (md == BANK_B_VIEW))
        else $error("main select wrong");
    a_pip_split: assert property (ok && md == BANK_SPLIT |->
        (ctrl_d[12] || PIP1_GAMMA_EN == !ps[1] && PIP1_GAMMA_BANK_B == !ps[1])
        && (ctrl_d[13] || PIP2_GAMMA_EN == !ps[0]
        && PIP2_GAMMA_BANK_B == !ps[0]))
        else $error("overlay select wrong in split mode");
    a_pip_ignored: assert property (ok && md != BANK_SPLIT |->
        !PIP2_GAMMA_EN && (ctrl_d[12] || PIP1_GAMMA_EN == !md[1]
        && PIP1_GAMMA_BANK_B == (md == BANK_B_VIEW)))
        else $error("overlay field not ignored");
    a_host_grant: assert property (ok |-> HOST_BANK_A_EN == md[0]
        && HOST_BANK_B_EN == (md[1] == md[0]))
        else $error("host grant wrong");
endmodule : gamma_sel_monitor
bind window_gamma_lut_select gamma_sel_monitor #(.ADR_W(ADR_W))
    gamma_sel_monitor_inst (.MCLK, .RST, .CYC_I, .STB_I, .WE_I, .ADR_I,
    .SEL_I, .DAT_I, .DAT_O, .ACK_O, .MAIN_GAMMA_EN, .MAIN_GAMMA_BANK_B,
    .PIP1_GAMMA_EN, .PIP1_GAMMA_BANK_B, .PIP2_GAMMA_EN, .PIP2_GAMMA_BANK_B,
    .HOST_BANK_A_EN, .HOST_BANK_B_EN);
`default_nettype wire

// file: tb/tb_window_gamma_lut_select.sv
/* bench for the gamma bank select block: register access and selects.
   assumes the design package and the bound checker are compiled. */
`timescale 1ns/100ps
`default_nettype none
module tb_window_gamma_lut_select;
    import gamma_sel_pkg::*;
    logic        MCLK = 1'b0;
    logic        RST, CYC_I, STB_I, WE_I, ACK_O;
    logic [15:2] ADR_I;
    logic [3:0]  SEL_I;
    logic [31:0] DAT_I, DAT_O, q;
    logic        MAIN_GAMMA_EN, MAIN_GAMMA_BANK_B, PIP1_GAMMA_EN;
    logic        PIP1_GAMMA_BANK_B, PIP2_GAMMA_EN, PIP2_GAMMA_BANK_B;
    logic        HOST_BANK_A_EN, HOST_BANK_B_EN, EXPAND_EN, CLIP_DISABLE;
    logic        AUTO_INC, LUT_ENABLE;
    logic [1:0]  WRITE_COLOR;
    logic [7:0]  ov;
    logic [15:0] c;
    int          err_count, n_checks;
    localparam logic [15:0] CA = 16'h20f8; // control byte address
    localparam logic [15:0] SA = 16'h23c0; // status byte address
    assign ov = {HOST_BANK_B_EN, HOST_BANK_A_EN, PIP2_GAMMA_BANK_B,
                 PIP1_GAMMA_BANK_B, MAIN_GAMMA_BANK_B, PIP2_GAMMA_EN,
                 PIP1_GAMMA_EN, MAIN_GAMMA_EN};
    window_gamma_lut_select window_gamma_lut_select_inst (.MCLK, .RST,
        .CYC_I, .STB_I, .WE_I, .ADR_I, .SEL_I, .DAT_I, .DAT_O, .ACK_O,
        .MAIN_GAMMA_EN, .MAIN_GAMMA_BANK_B, .PIP1_GAMMA_EN,
        .PIP1_GAMMA_BANK_B, .PIP2_GAMMA_EN, .PIP2_GAMMA_BANK_B,
        .HOST_BANK_A_EN, .HOST_BANK_B_EN, .WRITE_COLOR, .EXPAND_EN,
        .CLIP_DISABLE, .AUTO_INC, .LUT_ENABLE);
    always #12.5 MCLK = ~MCLK;
    ////////////////////////////////////////////////////////////////////////
    task results;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results
    task chk(input string nm, input logic [31:0] got, input logic [31:0] ex);
        n_checks++;
        if (got !== ex)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    // classic cycle: held until ack is seen high at a rising edge
    task wb(input logic w, input logic [15:0] a, input logic [3:0] b,
            input logic [31:0] d);
        @(posedge MCLK);
        CYC_I <= 1'b1;
        STB_I <= 1'b1;
        WE_I  <= w;
        ADR_I <= a[15:2];
        SEL_I <= b;
        DAT_I <= d;
        do @(posedge MCLK); while (ACK_O !== 1'b1);
        q = DAT_O;
        CYC_I <= 1'b0;
        STB_I <= 1'b0;
        // idle lines show the inverse, so a late sample cannot pass
        WE_I  <= ~w;
        ADR_I <= ~a[15:2];
        DAT_I <= ~d;
    endtask : wb
    // expected status word worked out from a control value
    function automatic logic [10:0] stat(input logic [15:0] v);
        logic [1:0] m;
        logic [2:0] a, p, e;
        m = v[5:4];
        a = {m == BANK_SPLIT && !v[10], !m[1] || m == BANK_SPLIT && !v[11],
             m != BANK_HOST};
        p = {v[13], v[12], v[14]};
        e = a & ~p;
        return {m[1] == m[0], m[0], ~a & ~p,
                e & {1'b1, m[1] ^ m[0], m == BANK_B_VIEW}, e};
    endfunction : stat
    // the eight select outputs expected from a control value
    function automatic logic [7:0] ov_exp(input logic [15:0] v);
        logic [10:0] s;
        s = stat(v);
        return {s[10:9], s[5:0]};
    endfunction : ov_exp
    ////////////////////////////////////////////////////////////////////////
    // watchdog well beyond the roughly 1500 cycles the tests need
    initial
    begin
        repeat (20000) @(posedge MCLK);
        err_count++;
        results();
    end
    initial
    begin
        {CYC_I, STB_I, WE_I, ADR_I, SEL_I, DAT_I} = '0;
        RST = 1'b1;
        repeat (10) @(posedge MCLK);
        RST <= 1'b0;
        repeat (2) @(posedge MCLK);
        chk("sel after reset", ov, ov_exp(16'h0));
        wb(1'b0, CA, 4'hf, 32'h0);
        chk("control reset", q, 32'h0);
        // every mode, overlay choice and bypass pattern, with spare bits
        for (int i = 0; i < 128; i++)
        begin
            c = {1'b1, i[6:2], ~i[3:2], 2'b11, i[1:0], i[3:0]};
            wb(1'b1, CA, 4'h3, {16'hffff, c});
            repeat (2) @(posedge MCLK);
            c = c & CONTROL_MASK;
            chk("selects", ov, ov_exp(c));
            chk("fields", {WRITE_COLOR, EXPAND_EN, CLIP_DISABLE, AUTO_INC,
                LUT_ENABLE}, {c[9:8], c[3:0]});
            wb(1'b0, CA, 4'hf, 32'h0);
            chk("control", q, {16'h0, c});
            wb(1'b0, SA, 4'hf, 32'h0);
            chk("status", q, {21'h0, stat(c)});
        end
        // byte lanes, status write, unmapped place
        wb(1'b1, CA, 4'h3, 32'h0);
        wb(1'b1, CA, 4'h2, 32'hffffffff);
        wb(1'b1, SA, 4'hf, 32'hffffffff);
        wb(1'b1, 16'h0010, 4'hf, 32'hffffffff);
        wb(1'b0, 16'h0010, 4'hf, 32'h0);
        chk("unmapped", q, 32'h0);
        wb(1'b0, CA, 4'hf, 32'h0);
        chk("lane one", q, 32'h7f00);
        wb(1'b0, SA, 4'hf, 32'h0);
        chk("status ro", q, {21'h0, stat(16'h7f00)});
        // reset in mid-run returns the control register to zero
        RST <= 1'b1;
        repeat (2) @(posedge MCLK);
        RST <= 1'b0;
        wb(1'b0, CA, 4'hf, 32'h0);
        chk("control re-reset", q, 32'h0);
        chk("sel re-reset", ov, ov_exp(16'h0));
        results();
    end
endmodule : tb_window_gamma_lut_select
`default_nettype wire
